// ---- rtl/gisp_pkg.sv ----
// Shared constants and types for the gauge two-wire slave port.
// Behaviour
// [R1] Accept single read, incremental read, quick read, single write and incremental write.
// [R2] Answer only the 7-bit address 1010101: first byte 0xAA write, 0xAB read.
// [R3] A quick read returns data at the current address pointer.
// [R4] Pointer advances by one on every acknowledged data byte, either side acknowledging.
// [R5] Write data bytes in one transfer land at consecutive command locations.
// [R6] A data byte written to a read-only location is not acknowledged.
// [R7] A command byte above 0x6B is not acknowledged and returns no data.
// [R8] After the bus is held low about 2 seconds, release both lines.
// [R9] If a line stays low after that release, enter low-power sleep.
// [R10] First byte after a write address is the command, loaded into the pointer.
// [R11] Master acknowledges every read byte but the last, then not-acknowledges and stops.
package gisp_pkg;
	localparam logic [6:0] DEV_ADDR = 7'h55;
	localparam logic [7:0] ADDR_WR_BYTE = {DEV_ADDR, 1'b0};
	localparam logic [7:0] ADDR_RD_BYTE = {DEV_ADDR, 1'b1};
	localparam logic [7:0] CMD_TOP = 8'h6b;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned BUS_STUCK_TIMEOUT_MS = 2000;
	localparam int unsigned BUS_STUCK_TIMEOUT_CYCLES = BUS_STUCK_TIMEOUT_MS * CLK_MHZ * 1000;
	localparam int unsigned SETTLE_CYCLES = 16;
	localparam int STUCK_W = 30;
	localparam int FIFO_DEPTH = 8;
	localparam logic [7:0] PTR_RESET = 8'h00;

	// One buffered write: command location and the byte for it.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} gisp_wr_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_CMD,
		ST_CMD_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK
	} gisp_state_t;
endpackage : gisp_pkg

// ---- rtl/gisp_slave_port.sv ----
// Two-wire slave port of the gauge with its write buffer.
`timescale 1ns/10ps
`default_nettype none

// Write buffer with a registered output stage; DEPTH must be a power of two.
module gisp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic mclk_in, // Core clock.
	input wire logic rst_n_in, // Asynchronous reset, active low.
	input wire logic in_valid_in, // Word offered.
	input wire logic [WIDTH-1:0] in_data_in, // Word offered.
	output logic in_ready_out, // Room for a word.
	output logic out_valid_out, // Head word valid.
	output logic [WIDTH-1:0] out_data_out, // Head word.
	input wire logic out_ready_in // Consumer takes the head.
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic ov_q;
	logic [WIDTH-1:0] od_q;
	wire push = in_valid_in & in_ready_out;
	wire load = (cnt_q != '0) & (~ov_q | out_ready_in);

	// Full is honest: the slave stretches the clock while this is low.
	assign in_ready_out = cnt_q < (AW + 1)'(DEPTH);
	assign out_valid_out = ov_q;
	assign out_data_out = od_q;

	// Storage needs no reset; pointers, count, valid flag and output data are reset.
	always_ff @(posedge mclk_in) begin
		if (push) begin
			mem_q[wp_q] <= in_data_in;
		end
	end

	// Pointers, fill count and output stage.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
			ov_q <= 1'b0;
			od_q <= '0;
		end else begin
			wp_q <= wp_q + AW'(push);
			rp_q <= rp_q + AW'(load);
			cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(load);
			if (load) begin
				od_q <= mem_q[rp_q];
				ov_q <= 1'b1;
			end else if (out_ready_in) begin
				ov_q <= 1'b0;
			end
		end
	end
endmodule : gisp_fifo

// Slave engine: address match, command pointer, reads, buffered writes, bus timeout.
module gisp_slave_port #(
	parameter int unsigned STUCK_CYCLES = gisp_pkg::BUS_STUCK_TIMEOUT_CYCLES
) (
	input wire logic mclk_in, // 250 MHz core clock.
	input wire logic rst_n_in, // Asynchronous reset, active low.
	input wire logic scl_in, // Clock pin level.
	output logic scl_out, // Clock pin drive value, always low.
	output logic scl_oe_out, // High while the clock is held low.
	input wire logic sda_in, // Data pin level.
	output logic sda_out, // Data pin drive value, always low.
	output logic sda_oe_out, // High while data is pulled low.
	output logic [7:0] rd_addr_out, // Address pointer, location to read.
	input wire logic [7:0] rd_data_in, // Byte at rd_addr_out, same clock.
	input wire logic rd_ro_in, // Location at rd_addr_out is read-only.
	output var gisp_pkg::gisp_wr_t wr_out, // Buffered write word.
	output logic wr_valid_out, // Write word valid.
	input wire logic wr_ready_in, // Consumer takes the write word.
	output logic bus_err_out, // Bus timeout seen, lines still low.
	output logic sleep_out // Low-power sleep request.
);
	localparam logic [gisp_pkg::STUCK_W-1:0] STUCK_HIT =
		gisp_pkg::STUCK_W'(STUCK_CYCLES - 1);
	localparam logic [gisp_pkg::STUCK_W-1:0] SLEEP_AT =
		gisp_pkg::STUCK_W'(STUCK_CYCLES - 1 + gisp_pkg::SETTLE_CYCLES);

	gisp_pkg::gisp_state_t state_q, state_d;
	logic [2:0] scl_sync_q;
	logic [2:0] sda_sync_q;
	logic [2:0] cnt_q, cnt_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] ptr_q, ptr_d;
	logic done_q, done_d;
	logic rw_q, rw_d;
	logic acked_q, acked_d;
	logic sda_oe_q, sda_oe_d;
	logic scl_oe_q, scl_oe_d;
	logic push;
	logic [gisp_pkg::STUCK_W-1:0] low_cnt_q;
	logic err_q;
	logic sleep_q;
	logic drive_q;
	logic fifo_in_ready;
	gisp_pkg::gisp_wr_t push_word;

	// Line decode works on the second and third sync stages only.
	wire scl_s = scl_sync_q[1];
	wire scl_p = scl_sync_q[2];
	wire sda_s = sda_sync_q[1];
	wire sda_p = sda_sync_q[2];
	wire scl_rise = scl_s & ~scl_p;
	wire scl_fall = ~scl_s & scl_p;
	wire start_det = scl_s & scl_p & sda_p & ~sda_s;
	wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
	wire bus_high = scl_s & sda_s;
	wire stuck_hit = low_cnt_q == STUCK_HIT;
	wire receiving = state_q inside {gisp_pkg::ST_ADDR, gisp_pkg::ST_CMD, gisp_pkg::ST_WR};
	// A byte ends at the falling edge after its eighth bit, or while we stall.
	wire byte_end = done_q & (scl_fall | scl_oe_q);
	wire addr_match = shift_q == gisp_pkg::ADDR_WR_BYTE || shift_q == gisp_pkg::ADDR_RD_BYTE; // [R2]
	wire cmd_in_range = shift_q <= gisp_pkg::CMD_TOP;
	assign push_word = '{addr: ptr_q, data: shift_q};

	// Protocol engine; each branch changes SDA only after a falling clock edge, except the timeout, start and stop releases.
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		done_d = done_q;
		rw_d = rw_q;
		acked_d = acked_q;
		sda_oe_d = sda_oe_q;
		scl_oe_d = 1'b0;
		push = 1'b0;
		if (stuck_hit) begin
			state_d = gisp_pkg::ST_IDLE; // [R8]
			sda_oe_d = 1'b0; // [R8]
			done_d = 1'b0;
		end else if (start_det) begin
			state_d = gisp_pkg::ST_ADDR;
			cnt_d = '0;
			done_d = 1'b0;
			sda_oe_d = 1'b0;
		end else if (stop_det) begin
			state_d = gisp_pkg::ST_IDLE;
			sda_oe_d = 1'b0;
			done_d = 1'b0;
		end else begin
			if (receiving && scl_rise) begin
				shift_d = {shift_q[6:0], sda_s};
				cnt_d = cnt_q + 3'h1;
				done_d = cnt_q == gisp_pkg::BIT_LAST;
			end
			unique case (state_q)
				gisp_pkg::ST_IDLE: begin
				end
				gisp_pkg::ST_ADDR: begin
					if (byte_end) begin
						done_d = 1'b0;
						rw_d = shift_q[0];
						sda_oe_d = addr_match; // [R2]
						state_d = addr_match ? gisp_pkg::ST_ADDR_ACK : gisp_pkg::ST_IDLE; // [R2]
					end
				end
				gisp_pkg::ST_CMD: begin
					if (byte_end) begin
						done_d = 1'b0;
						if (cmd_in_range) begin
							ptr_d = shift_q; // [R10]
							sda_oe_d = 1'b1;
							state_d = gisp_pkg::ST_CMD_ACK;
						end else begin
							state_d = gisp_pkg::ST_IDLE; // [R7]
						end
					end
				end
				gisp_pkg::ST_WR: begin
					if (byte_end) begin
						if (rd_ro_in) begin
							done_d = 1'b0;
							state_d = gisp_pkg::ST_IDLE; // [R6]
						end else if (fifo_in_ready) begin
							done_d = 1'b0;
							push = 1'b1; // [R5]
							scl_oe_d = scl_oe_q; // Hold a stretch one cycle so SDA is low before SCL rises.
							ptr_d = ptr_q + 8'h01; // [R4]
							sda_oe_d = 1'b1;
							state_d = gisp_pkg::ST_WR_ACK;
						end else begin
							scl_oe_d = 1'b1; // Buffer full: hold the clock low.
						end
					end
				end
				gisp_pkg::ST_ADDR_ACK, gisp_pkg::ST_CMD_ACK, gisp_pkg::ST_WR_ACK: begin
					if (scl_fall) begin
						cnt_d = '0;
						if (state_q == gisp_pkg::ST_ADDR_ACK && rw_q) begin
							shift_d = rd_data_in; // [R3]
							sda_oe_d = ~rd_data_in[7];
							state_d = gisp_pkg::ST_RD; // [R1]
						end else begin
							sda_oe_d = 1'b0;
							state_d = state_q == gisp_pkg::ST_ADDR_ACK ?
								gisp_pkg::ST_CMD : gisp_pkg::ST_WR; // [R1]
						end
					end
				end
				gisp_pkg::ST_RD: begin
					if (scl_rise) begin
						cnt_d = cnt_q + 3'h1;
						done_d = cnt_q == gisp_pkg::BIT_LAST;
					end else if (scl_fall && done_q) begin
						done_d = 1'b0;
						sda_oe_d = 1'b0;
						state_d = gisp_pkg::ST_RD_ACK;
					end else if (scl_fall) begin
						shift_d = {shift_q[6:0], 1'b0};
						sda_oe_d = ~shift_q[6];
					end
				end
				gisp_pkg::ST_RD_ACK: begin
					if (scl_rise) begin
						acked_d = ~sda_s; // [R11]
						ptr_d = ptr_q + {7'h00, ~sda_s}; // [R4]
					end else if (scl_fall && acked_q) begin
						cnt_d = '0;
						shift_d = rd_data_in; // [R1]
						sda_oe_d = ~rd_data_in[7];
						state_d = gisp_pkg::ST_RD;
					end else if (scl_fall) begin
						state_d = gisp_pkg::ST_IDLE; // [R11]
					end
				end
			endcase
		end
	end

	// Two-stage synchronisers plus one history stage for edge detection.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			scl_sync_q <= 3'h7;
			sda_sync_q <= 3'h7;
		end else begin
			scl_sync_q <= {scl_sync_q[1:0], scl_in};
			sda_sync_q <= {sda_sync_q[1:0], sda_in};
		end
	end

	// Engine state.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= gisp_pkg::ST_IDLE;
			cnt_q <= '0;
			shift_q <= '0;
			ptr_q <= gisp_pkg::PTR_RESET;
			done_q <= 1'b0;
			rw_q <= 1'b0;
			acked_q <= 1'b0;
			sda_oe_q <= 1'b0;
			scl_oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			done_q <= done_d;
			rw_q <= rw_d;
			acked_q <= acked_d;
			sda_oe_q <= sda_oe_d;
			scl_oe_q <= scl_oe_d;
		end
	end

	// Bus-low watchdog; it also counts our own stretch, so a stuck consumer cannot hang the bus.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			low_cnt_q <= '0;
			err_q <= 1'b0;
			sleep_q <= 1'b0;
			drive_q <= 1'b0;
		end else begin
			drive_q <= 1'b0;
			if (bus_high) begin
				low_cnt_q <= '0;
				err_q <= stuck_hit; // [R8] A timeout in the cycle the bus frees still reports.
				sleep_q <= 1'b0;
			end else begin
				if (low_cnt_q != SLEEP_AT) begin
					low_cnt_q <= low_cnt_q + 1'b1;
				end
				if (stuck_hit) begin
					err_q <= 1'b1; // [R8]
				end
				if (low_cnt_q == SLEEP_AT) begin
					sleep_q <= 1'b1; // [R9]
				end
			end
		end
	end

	gisp_fifo #(.WIDTH($bits(gisp_pkg::gisp_wr_t)), .DEPTH(gisp_pkg::FIFO_DEPTH)) u_wr_fifo (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.in_valid_in(push),
		.in_data_in(push_word),
		.in_ready_out(fifo_in_ready),
		.out_valid_out(wr_valid_out),
		.out_data_out(wr_out),
		.out_ready_in(wr_ready_in)
	);

	// Open-drain outputs: value is always low, only the enables move.
	assign scl_out = drive_q;
	assign sda_out = drive_q;
	assign scl_oe_out = scl_oe_q;
	assign sda_oe_out = sda_oe_q;
	assign rd_addr_out = ptr_q;
	assign bus_err_out = err_q;
	assign sleep_out = sleep_q;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	a_addr_match_ack: assert property ($rose(state_q == gisp_pkg::ST_ADDR_ACK) |-> // [R2]
		sda_oe_q && shift_q[7:1] == gisp_pkg::DEV_ADDR) else $error("ack without address match");
	a_addr_miss_idle: assert property (state_q == gisp_pkg::ST_ADDR && byte_end && !addr_match // [R2]
		&& !stuck_hit && !start_det && !stop_det |=> state_q == gisp_pkg::ST_IDLE && !sda_oe_q)
		else $error("foreign address was acknowledged");
	a_quick_read_data: assert property (state_q == gisp_pkg::ST_ADDR_ACK && rw_q && scl_fall // [R3]
		&& !stuck_hit && !start_det && !stop_det |=> state_q == gisp_pkg::ST_RD
		&& shift_q == $past(rd_data_in)) else $error("quick read did not load pointer data");
	a_ptr_wr_step: assert property (push |=> ptr_q == $past(ptr_q) + 8'h01) // [R4]
		else $error("pointer did not advance on write ack");
	a_ptr_rd_step: assert property (state_q == gisp_pkg::ST_RD_ACK && scl_rise && !sda_s // [R4]
		&& !stuck_hit && !start_det && !stop_det |=> ptr_q == $past(ptr_q) + 8'h01)
		else $error("pointer did not advance on master ack");
	a_wr_consecutive: assert property (push |-> push_word.addr == ptr_q // [R5]
		&& push_word.data == shift_q ##1 push_word.addr == $past(ptr_q) + 8'h01)
		else $error("write byte not at pointer location");
	a_ro_data_nack: assert property (state_q == gisp_pkg::ST_WR && byte_end && rd_ro_in // [R6]
		&& !stuck_hit && !start_det && !stop_det |=> !sda_oe_q && !push)
		else $error("read-only write was acknowledged");
	a_cmd_top_nack: assert property (state_q == gisp_pkg::ST_CMD && byte_end && !cmd_in_range // [R7]
		&& !stuck_hit && !start_det && !stop_det |=> state_q == gisp_pkg::ST_IDLE
		&& !sda_oe_q [*2]) else $error("out-of-range command was acknowledged");
	a_cmd_ptr_load: assert property ($rose(state_q == gisp_pkg::ST_CMD_ACK) |-> // [R10]
		ptr_q == $past(shift_q) && ptr_q <= gisp_pkg::CMD_TOP) else $error("command not loaded");
	a_timeout_release: assert property (stuck_hit |=> !sda_oe_q && !scl_oe_q // [R8]
		&& bus_err_out && state_q == gisp_pkg::ST_IDLE) else $error("lines not released");
	a_sleep_entry: assert property ($rose(sleep_q) |-> bus_err_out // [R9]
		&& !$past(sda_oe_q, 8) && !$past(scl_oe_q, 8))
		else $error("sleep without prior release");

	c_write_two: cover property (push ##[1:1000] push);
	c_read_two: cover property (state_q == gisp_pkg::ST_RD_ACK && acked_q ##1 state_q == gisp_pkg::ST_RD);
	c_stretch: cover property (scl_oe_q [*3]);
	c_sleep: cover property ($rose(sleep_q));
endmodule : gisp_slave_port

`default_nettype wire

// ---- tb/gisp_i2c_master.sv ----
// Bus master model that drives both lines of the two-wire port.
`timescale 1ns/10ps
`default_nettype none
module gisp_i2c_master (
	input wire logic mclk_in, // Core clock for bit timing.
	input wire logic scl_in, // Clock line level.
	input wire logic sda_in, // Data line level.
	output logic scl_out, // Clock drive, 1 releases.
	output logic sda_out // Data drive, 1 releases.
);
	// Lines start released; the clock stands still between frames.
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	// Ten core cycles a half bit keeps every phase above the port's minimum.
	task automatic half();
		repeat (10) @(negedge mclk_in);
	endtask : half
	// Raise the clock and wait while the port stretches it; the bench's cycle ceiling ends a hang.
	task automatic rise();
		scl_out = 1'b1;
		while (!scl_in)
			@(negedge mclk_in);
		half();
	endtask : rise
	// Start or repeated start.
	task automatic start();
		sda_out = 1'b1;
		half();
		rise();
		sda_out = 1'b0;
		half();
		scl_out = 1'b0;
		half();
	endtask : start
	task automatic stop();
		sda_out = 1'b0;
		half();
		rise();
		sda_out = 1'b1;
		half();
	endtask : stop
	// Data moves half a bit after the fall, so it never looks like a start or stop.
	task automatic clk_bit(input logic b, output logic s);
		sda_out = b;
		half();
		rise();
		s = sda_in;
		scl_out = 1'b0;
		half();
	endtask : clk_bit
	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], s);
		clk_bit(1'b1, s);
		ack = !s;
	endtask : wbyte
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(last, s);
	endtask : rbyte
endmodule : gisp_i2c_master
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the gauge two-wire slave port.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic wr_ready_in = 1'b0;
	logic scl_oe, sda_oe, wr_valid, bus_err, sleep, ack;
	logic scl_drv, sda_drv;
	logic [7:0] rd_addr, d;
	gisp_pkg::gisp_wr_t wr_word;
	gisp_pkg::gisp_wr_t wq[$];
	int failures = 0;
	int check_count = 0;
	int cyc = 0;
	int low_run = 0;
	wire logic m_scl, m_sda;
	// Pulled-up lines: any party driving low wins; the port pulls only with a low drive value.
	wire logic scl = m_scl & (scl_drv | ~scl_oe);
	wire logic sda = m_sda & (sda_drv | ~sda_oe);
	// Simple location store; one location is read-only.
	wire logic [7:0] rd_data = rd_addr ^ 8'h5a;
	wire logic rd_ro = rd_addr == 8'h20;

	gisp_slave_port #(.STUCK_CYCLES(2000)) i_gisp_slave_port (
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl), .scl_out(scl_drv),
		.scl_oe_out(scl_oe), .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe),
		.rd_addr_out(rd_addr), .rd_data_in(rd_data), .rd_ro_in(rd_ro),
		.wr_out(wr_word), .wr_valid_out(wr_valid), .wr_ready_in(wr_ready_in),
		.bus_err_out(bus_err), .sleep_out(sleep));
	gisp_i2c_master i_gisp_i2c_master (.mclk_in(mclk_in), .scl_in(scl), .sda_in(sda),
		.scl_out(m_scl), .sda_out(m_sda));

	initial begin
		forever #2 mclk_in = ~mclk_in;
	end
	// Collect every word the consumer takes; a hang is cut short here.
	always @(posedge mclk_in) begin
		if (wr_valid && wr_ready_in)
			wq.push_back(wr_word);
		// Cycles since both lines were last high, to time the bus watchdog.
		if (scl && sda)
			low_run <= 0;
		else
			low_run <= low_run + 1;
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			stop_test();
		end
	end

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic wr(input logic [7:0] b, input logic exp, input string name);
		i_gisp_i2c_master.wbyte(b, ack);
		check(name, {7'h00, exp}, {7'h00, ack});
	endtask : wr
	task automatic rd(input logic last, input logic [7:0] exp);
		i_gisp_i2c_master.rbyte(last, d);
		check("read data", exp, d);
	endtask : rd
	task automatic st();
		i_gisp_i2c_master.start();
	endtask : st
	task automatic sp();
		i_gisp_i2c_master.stop();
	endtask : sp
	task automatic wait_cycles(input int n);
		repeat (n) @(negedge mclk_in);
	endtask : wait_cycles

	// Ten bytes against a stalled consumer: nine fit, the tenth is stretched.
	task automatic t_write_fill();
		int n = 0;
		wq.delete();
		fork
			begin
				st();
				wr(8'haa, 1'b1, "write address");
				wr(8'h10, 1'b1, "command");
				for (int i = 0; i < 10; i++)
					wr(8'(8'hc0 + i), 1'b1, "write data");
				sp();
			end
			begin
				while (!scl_oe && n < 20000) begin
					wait_cycles(1);
					n++;
				end
				check("stretch", 8'h01, {7'h00, scl_oe});
				wait_cycles(50);
				wr_ready_in = 1'b1;
			end
		join
		wait_cycles(20);
		check("word count", 8'h0a, 8'(wq.size()));
		foreach (wq[i]) begin
			check("word address", 8'(8'h10 + i), wq[i].addr);
			check("word data", 8'(8'hc0 + i), wq[i].data);
		end
		check("pointer", 8'h1a, rd_addr);
		$display("write and buffer fill test done");
	endtask : t_write_fill

	// Combined read, then quick reads from the pointer that it left.
	task automatic t_read();
		st();
		wr(8'haa, 1'b1, "write address");
		wr(8'h40, 1'b1, "command");
		st();
		wr(8'hab, 1'b1, "read address");
		rd(1'b0, 8'h40 ^ 8'h5a);
		rd(1'b1, 8'h41 ^ 8'h5a);
		sp();
		check("pointer", 8'h41, rd_addr);
		st();
		wr(8'hab, 1'b1, "quick address");
		rd(1'b0, 8'h41 ^ 8'h5a);
		rd(1'b1, 8'h42 ^ 8'h5a);
		sp();
		$display("read test done");
	endtask : t_read

	// Wrong address, command past the top, write to a read-only location.
	task automatic t_refuse();
		st();
		wr(8'ha8, 1'b0, "foreign address");
		sp();
		st();
		wr(8'haa, 1'b1, "write address");
		wr(8'h6c, 1'b0, "command 6c");
		sp();
		// The top location stays readable: a one-byte combined read of it.
		st();
		wr(8'haa, 1'b1, "write address");
		wr(8'h6b, 1'b1, "command 6b");
		st();
		wr(8'hab, 1'b1, "read address");
		rd(1'b1, 8'h6b ^ 8'h5a);
		sp();
		wq.delete();
		st();
		wr(8'haa, 1'b1, "write address");
		wr(8'h20, 1'b1, "command");
		wr(8'h77, 1'b0, "read-only data");
		sp();
		wait_cycles(20);
		check("read-only words", 8'h00, 8'(wq.size()));
		check("pointer", 8'h20, rd_addr);
		$display("refusal test done");
	endtask : t_refuse

	// Master stops clocking while the port holds the acknowledge.
	task automatic t_timeout();
		int n = 0;
		logic s;
		st();
		for (int i = 7; i >= 0; i--)
			i_gisp_i2c_master.clk_bit(gisp_pkg::ADDR_WR_BYTE[i], s);
		i_gisp_i2c_master.sda_out = 1'b1;
		wait_cycles(10);
		check("ack held", 8'h01, {7'h00, sda_oe});
		while (!bus_err && n < 2100) begin
			wait_cycles(1);
			n++;
		end
		check("timeout late", 8'h01, {7'h00, bus_err});
		// Watchdog length of 2000 plus the two synchroniser stages, with a little slack.
		check("timeout early", 8'h01, {7'h00, low_run >= 2000 && low_run <= 2004});
		check("sda released", 8'h01, {7'h00, !sda_oe && !scl_oe});
		wait_cycles(20);
		check("sleep", 8'h01, {7'h00, sleep});
		i_gisp_i2c_master.scl_out = 1'b1;
		wait_cycles(10);
		check("cleared", 8'h00, {6'h00, bus_err, sleep});
		$display("bus timeout test done");
	endtask : t_timeout

	task automatic stop_test();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	initial begin
		wait_cycles(10);
		rst_n_in = 1'b1;
		wait_cycles(10);
		check("reset pointer", 8'h00, rd_addr);
		t_write_fill();
		t_read();
		t_refuse();
		t_timeout();
		stop_test();
	end
endmodule : tb
`default_nettype wire
